// ==== hw/cag_core.sv ====
// Effective-address generation and special instructions of an 8-bit core.
// Assumes memory answers a read with data one cycle after mem_rd shows.
`timescale 1ns/1ps
`include "cag_regs.svh"

module cag_core (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic req_valid,
  output logic req_ready,
  input wire cag_pkg::cag_op_e req_op,
  input wire logic [7:0] req_opcode,
  input wire logic [7:0] req_opnd1,
  input wire logic [7:0] req_opnd2,
  input wire logic [1:0] req_len,
  input wire logic req_word,
  output logic done,
  output logic [15:0] ea,
  output logic [2:0] bit_sel,
  output logic [15:0] imm_data,
  output logic imm_word,
  output logic [15:0] pc,
  output logic [15:0] acc,
  output logic [15:0] tmp,
  output logic [15:0] sp,
  output logic [15:0] index_reg,
  output logic [15:0] extra_pointer,
  output logic [2:0] direct_bank_pointer,
  output logic [4:0] bank_select_pointer,
  output logic zero_flag,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  cag_pkg::cag_core_s r_reg;
  cag_pkg::cag_core_s r_next;
  logic [15:0] next_pc;
  logic [15:0] ret_addr;
  logic [15:0] disp;
  logic [15:0] dir_addr;
  logic [15:0] vec_addr;
  logic [15:0] load_val;
  logic div_done;
  logic [15:0] div_quo;
  logic [15:0] div_rem;

  cag_divider u_cag_divider (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .start(r_reg.div_start),
    .dividend(r_reg.tmp),
    .divisor(r_reg.acc),
    .done(div_done),
    .quotient(div_quo),
    .remainder(div_rem)
  );

  assign req_ready = (r_reg.state == cag_pkg::ST_IDLE);

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.mem_rd = 1'b0;
    r_next.mem_wr = 1'b0;
    r_next.div_start = 1'b0;
    next_pc = r_reg.pc + {14'h0000, req_len};
    ret_addr = r_reg.pc + `CAG_CALLV_LEN;
    disp = {{8{req_opnd1[7]}}, req_opnd1};
    dir_addr = {8'h00, req_opnd1};
    if (req_opnd1 >= `CAG_DIR_LIMIT) begin
      dir_addr = {8'h00, req_opnd1} +
        {6'h00, r_reg.dp, 7'h00};
    end
    vec_addr = `CAG_VEC_BASE + {12'h000, req_opcode[2:0], 1'b0};
    load_val = {req_opnd1, req_opnd2};
    unique case (r_reg.state)
      cag_pkg::ST_IDLE: begin
        if (req_valid) begin
          r_next.pc = next_pc;
          unique case (req_op)
            cag_pkg::OP_DIRECT: begin
              r_next.ea = dir_addr;
              r_next.done = 1'b1;
            end
            cag_pkg::OP_BITDIR: begin
              r_next.ea = dir_addr;
              r_next.bit_sel = req_opcode[2:0];
              r_next.done = 1'b1;
            end
            cag_pkg::OP_EXT: begin
              r_next.ea = {req_opnd1, req_opnd2};
              r_next.done = 1'b1;
            end
            cag_pkg::OP_INDEX: begin
              r_next.ea = r_reg.ix + disp;
              r_next.done = 1'b1;
            end
            cag_pkg::OP_POINTER: begin
              r_next.ea = r_reg.ep;
              r_next.done = 1'b1;
            end
            cag_pkg::OP_BANKREG: begin
              r_next.ea = {`CAG_GREG_HI, r_reg.rp,
                req_opcode[2:0]};
              r_next.done = 1'b1;
            end
            cag_pkg::OP_IMM: begin
              r_next.imm_word = req_word;
              r_next.imm = req_word ? {req_opnd1, req_opnd2} :
                {8'h00, req_opnd1};
              r_next.done = 1'b1;
            end
            cag_pkg::OP_VECTOR: begin
              r_next.mem_addr = vec_addr;
              r_next.mem_rd = 1'b1;
              r_next.state = cag_pkg::ST_VLO;
            end
            cag_pkg::OP_REL: begin
              r_next.pc = next_pc + disp;
              r_next.done = 1'b1;
            end
            cag_pkg::OP_JMPA: begin
              r_next.pc = r_reg.acc;
              r_next.done = 1'b1;
            end
            cag_pkg::OP_PCCAP: begin
              r_next.acc = next_pc;
              r_next.done = 1'b1;
            end
            cag_pkg::OP_MULU: begin
              r_next.acc = {8'h00, r_reg.acc[7:0]} *
                {8'h00, r_reg.tmp[7:0]};
              r_next.done = 1'b1;
            end
            cag_pkg::OP_DIVU: begin
              if (r_reg.acc == 16'h0000) begin
                r_next.zf = 1'b1;
                r_next.done = 1'b1;
              end else begin
                r_next.zf = 1'b0;
                r_next.div_start = 1'b1;
                r_next.state = cag_pkg::ST_DIV;
              end
            end
            cag_pkg::OP_PCSWAP: begin
              r_next.pc = r_reg.acc;
              r_next.acc = next_pc;
              r_next.done = 1'b1;
            end
            cag_pkg::OP_CALLV: begin
              r_next.pc = ret_addr;
              r_next.sp = r_reg.sp - `CAG_RET_BYTES;
              r_next.mem_addr = r_reg.sp - `CAG_RET_BYTES;
              r_next.mem_wdata = ret_addr[15:8];
              r_next.mem_wr = 1'b1;
              r_next.vec_num = req_opcode[2:0];
              r_next.state = cag_pkg::ST_CWLO;
            end
            cag_pkg::OP_LOAD: begin
              r_next.pc = r_reg.pc;
              unique case (req_opcode[2:0])
                3'h0: r_next.acc = load_val;
                3'h1: r_next.tmp = load_val;
                3'h2: r_next.ix = load_val;
                3'h3: r_next.ep = load_val;
                3'h4: r_next.sp = load_val;
                3'h5: r_next.pc = load_val;
                3'h6: r_next.dp = req_opnd2[2:0];
                3'h7: r_next.rp = req_opnd2[4:0];
              endcase
              r_next.done = 1'b1;
            end
          endcase
        end
      end
      cag_pkg::ST_CWLO: begin
        r_next.mem_addr = r_reg.sp + 16'h0001;
        r_next.mem_wdata = r_reg.pc[7:0];
        r_next.mem_wr = 1'b1;
        r_next.state = cag_pkg::ST_CVEC;
      end
      cag_pkg::ST_CVEC: begin
        r_next.mem_addr = `CAG_VEC_BASE +
          {12'h000, r_reg.vec_num, 1'b0};
        r_next.mem_rd = 1'b1;
        r_next.state = cag_pkg::ST_VLO;
      end
      cag_pkg::ST_VLO: begin
        r_next.mem_addr = r_reg.mem_addr + 16'h0001;
        r_next.mem_rd = 1'b1;
        r_next.state = cag_pkg::ST_VEND;
      end
      cag_pkg::ST_VEND: begin
        r_next.vec_hi = mem_rdata;
        r_next.state = cag_pkg::ST_VFIN;
      end
      cag_pkg::ST_VFIN: begin
        r_next.pc = {r_reg.vec_hi, mem_rdata};
        r_next.done = 1'b1;
        r_next.state = cag_pkg::ST_IDLE;
      end
      cag_pkg::ST_DIV: begin
        if (div_done) begin
          r_next.acc = div_quo;
          r_next.tmp = div_rem;
          r_next.done = 1'b1;
          r_next.state = cag_pkg::ST_IDLE;
        end
      end
      default: begin
        r_next.state = cag_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.state <= cag_pkg::ST_IDLE;
      r_reg.pc <= `CAG_WORD_RST;
      r_reg.sp <= `CAG_WORD_RST;
      r_reg.dp <= `CAG_DP_RST;
      r_reg.rp <= `CAG_RP_RST;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;
  assign ea = r_reg.ea;
  assign bit_sel = r_reg.bit_sel;
  assign imm_data = r_reg.imm;
  assign imm_word = r_reg.imm_word;
  assign pc = r_reg.pc;
  assign acc = r_reg.acc;
  assign tmp = r_reg.tmp;
  assign sp = r_reg.sp;
  assign index_reg = r_reg.ix;
  assign extra_pointer = r_reg.ep;
  assign direct_bank_pointer = r_reg.dp;
  assign bank_select_pointer = r_reg.rp;
  assign zero_flag = r_reg.zf;
  assign mem_addr = r_reg.mem_addr;
  assign mem_rd = r_reg.mem_rd;
  assign mem_wr = r_reg.mem_wr;
  assign mem_wdata = r_reg.mem_wdata;

  logic take;
  assign take = clk_en && req_valid && req_ready;

  dir_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_DIRECT && !req_opnd1[7]
    |=> ea == {8'h00, $past(req_opnd1)})
    else $error("direct low operand remapped");
  dir_bank_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_DIRECT && req_opnd1[7]
    |=> ea >= 16'h0080 && ea <= 16'h047F &&
      ea[6:0] == $past(req_opnd1[6:0]))
    else $error("direct high operand outside bank window");
  bit_pick_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_BITDIR
    |=> bit_sel == $past(req_opcode[2:0]))
    else $error("bit select not from opcode");
  ext_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_EXT
    |=> ea == {$past(req_opnd1), $past(req_opnd2)})
    else $error("extended address byte order");
  index_sum_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_INDEX
    |=> ea == $past(r_reg.ix) + {{8{$past(req_opnd1[7])}}, $past(req_opnd1)})
    else $error("index address wrong");
  bank_reg_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_BANKREG
    |=> ea[15:8] == 8'h01 && ea[2:0] == $past(req_opcode[2:0]))
    else $error("banked register address wrong");
  rel_reach_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_REL && req_opnd1 == 8'hFE && req_len == 2'h2
    |=> pc == $past(r_reg.pc))
    else $error("self branch does not loop");
  mul_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_MULU
    |=> acc == $past(r_reg.acc[7:0]) * $past(r_reg.tmp[7:0]) &&
      $stable(tmp) && $stable(zero_flag))
    else $error("multiply result or side effects wrong");
  div_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_DIVU && r_reg.acc == 16'h0000
    |=> zero_flag && done && $stable(acc) && $stable(tmp))
    else $error("divide by zero not flagged");
  swap_pc_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_PCSWAP
    |=> pc == $past(r_reg.acc) && acc == $past(r_reg.pc) + $past(req_len))
    else $error("pc swap wrong");
  call_push_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && req_op == cag_pkg::OP_CALLV
    |=> mem_wr && mem_addr == sp && sp == $past(r_reg.sp) - 16'h0002)
    else $error("vector call push wrong");

endmodule

// ==== hw/cag_divider.sv ====
// Unsigned 16/16 restoring divider, one quotient bit per enabled cycle.
// Assumes start is a one-cycle pulse while not busy and divisor nonzero.
`timescale 1ns/1ps
`include "cag_regs.svh"

module cag_divider (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [15:0] dividend,
  input wire logic [15:0] divisor,
  output logic done,
  output logic [15:0] quotient,
  output logic [15:0] remainder
);

  cag_pkg::cag_div_s r_reg;
  cag_pkg::cag_div_s r_next;
  logic [16:0] shifted;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    shifted = {r_reg.rem[15:0], r_reg.quo[15]};
    if (start && !r_reg.busy) begin
      r_next.busy = 1'b1;
      r_next.cnt = `CAG_DIV_STEPS;
      r_next.quo = dividend;
      r_next.rem = 17'h00000;
      r_next.dvs = divisor;
    end else if (r_reg.busy) begin
      if (shifted >= {1'b0, r_reg.dvs}) begin
        r_next.rem = shifted - {1'b0, r_reg.dvs};
        r_next.quo = {r_reg.quo[14:0], 1'b1};
      end else begin
        r_next.rem = shifted;
        r_next.quo = {r_reg.quo[14:0], 1'b0};
      end
      r_next.cnt = r_reg.cnt - 5'h01;
      if (r_reg.cnt == 5'h01) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;
  assign quotient = r_reg.quo;
  assign remainder = r_reg.rem[15:0];

endmodule

// ==== hw/cag_pkg.sv ====
// Types shared by the address-generation core and its divider.
// Assumes the constants header is compiled alongside.
package cag_pkg;

  typedef enum logic [3:0] {
    OP_DIRECT  = 4'h0,
    OP_BITDIR  = 4'h1,
    OP_EXT     = 4'h2,
    OP_INDEX   = 4'h3,
    OP_POINTER = 4'h4,
    OP_BANKREG = 4'h5,
    OP_IMM     = 4'h6,
    OP_VECTOR  = 4'h7,
    OP_REL     = 4'h8,
    OP_JMPA    = 4'h9,
    OP_PCCAP   = 4'hA,
    OP_MULU    = 4'hB,
    OP_DIVU    = 4'hC,
    OP_PCSWAP  = 4'hD,
    OP_CALLV   = 4'hE,
    OP_LOAD    = 4'hF
  } cag_op_e;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CWLO = 7'h02,
    ST_CVEC = 7'h04,
    ST_VLO  = 7'h08,
    ST_VEND = 7'h10,
    ST_VFIN = 7'h20,
    ST_DIV  = 7'h40
  } cag_state_e;

  typedef struct packed {
    cag_state_e state;
    logic [15:0] pc;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] sp;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [2:0] dp;
    logic [4:0] rp;
    logic zf;
    logic [15:0] ea;
    logic [2:0] bit_sel;
    logic [15:0] imm;
    logic imm_word;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_rd;
    logic mem_wr;
    logic [2:0] vec_num;
    logic [7:0] vec_hi;
    logic div_start;
    logic done;
  } cag_core_s;

  typedef struct packed {
    logic busy;
    logic [4:0] cnt;
    logic [15:0] quo;
    logic [16:0] rem;
    logic [15:0] dvs;
    logic done;
  } cag_div_s;

endpackage

// ==== hw/cag_regs.svh ====
// Constants of the address-generation block: offsets, fields, resets, counts.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CAG_REGS_SVH
`define CAG_REGS_SVH

// Direct area: operands below this byte reach page zero unchanged
`define CAG_DIR_LIMIT 8'h80
// Position of the direct bank pointer inside the direct address
`define CAG_DIR_BANK_POS 7
// Upper address byte of banked general registers
`define CAG_GREG_HI 8'h01
// First byte of the vector table
`define CAG_VEC_BASE 16'hFFC0
// Length of the one-byte vector call
`define CAG_CALLV_LEN 16'h0001
// Stack space taken by a return address
`define CAG_RET_BYTES 16'h0002
// Reset values of the core registers
`define CAG_WORD_RST 16'h0000
`define CAG_DP_RST 3'h0
`define CAG_RP_RST 5'h00
// Divider step count, one quotient bit per step
`define CAG_DIV_STEPS 5'h10

`endif

// ==== test/cag_core_bench.sv ====
// Self-checking bench for the address-generation core.
// Assumes the memory model answers reads one cycle after the request.
`timescale 1ns/1ps

module cag_core_bench;
  logic clk_sys = 1'b0;
  logic nrst, clk_en, req_valid, req_ready, req_word, done, imm_word;
  cag_pkg::cag_op_e req_op;
  logic [7:0] req_opcode, req_opnd1, req_opnd2, mem_wdata, mem_rdata;
  logic [1:0] req_len;
  logic [15:0] ea, imm_data, pc, acc, tmp, sp, index_reg, extra_pointer;
  logic [15:0] mem_addr;
  logic [2:0] bit_sel, direct_bank_pointer;
  logic [4:0] bank_select_pointer;
  logic zero_flag, mem_rd, mem_wr;
  int errors, compares;

  always #20 clk_sys = ~clk_sys;

  cag_core u_cag_core (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_opcode(req_opcode), .req_opnd1(req_opnd1), .req_opnd2(req_opnd2),
    .req_len(req_len), .req_word(req_word), .done(done), .ea(ea),
    .bit_sel(bit_sel), .imm_data(imm_data), .imm_word(imm_word), .pc(pc),
    .acc(acc), .tmp(tmp), .sp(sp), .index_reg(index_reg),
    .extra_pointer(extra_pointer),
    .direct_bank_pointer(direct_bank_pointer),
    .bank_select_pointer(bank_select_pointer), .zero_flag(zero_flag),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  cag_mem_model u_cag_mem_model (
    .clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task conclude();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic note(input string name);
    $display("test %s finished", name);
  endtask

  // One request, held until taken, then a bounded wait for done
  task automatic run(input cag_pkg::cag_op_e o, input logic [7:0] code,
                     input logic [7:0] a, input logic [7:0] b,
                     input logic [1:0] len, input logic w, input int hold);
    int n;
    n = 0;
    req_op = o;
    req_opcode = code;
    req_opnd1 = a;
    req_opnd2 = b;
    req_len = len;
    req_word = w;
    req_valid = 1'b1;
    if (hold > 0) begin
      clk_en = 1'b0;
      repeat (hold) @(posedge clk_sys);
      #1;
      chk({15'h0000, done}, 16'h0000);
      clk_en = 1'b1;
    end
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 50) begin
      errors++;
      conclude();
    end
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 100) begin
      errors++;
      conclude();
    end
    @(posedge clk_sys);
    #1;
  endtask

  task automatic ld(input logic [2:0] t, input logic [15:0] v);
    run(cag_pkg::OP_LOAD, {5'h00, t}, v[15:8], v[7:0], 2'h3, 1'b1, 0);
  endtask

  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req_op = cag_pkg::OP_DIRECT;
    req_opcode = 8'h00;
    req_opnd1 = 8'h00;
    req_opnd2 = 8'h00;
    req_len = 2'h0;
    req_word = 1'b0;
    errors = 0;
    compares = 0;
    repeat (12) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    chk({15'h0000, req_ready}, 16'h0001);
    chk(pc, 16'h0000);
    for (int d = 0; d < 8; d++) begin
      ld(3'h6, {8'h00, 5'h1F, 3'(d)});
      chk({13'h0000, direct_bank_pointer}, {13'h0000, 3'(d)});
      run(cag_pkg::OP_DIRECT, 8'h00, 8'hC5, 8'h00, 2'h2, 1'b0, 0);
      chk(ea, 16'h00C5 + {6'h00, 3'(d), 7'h00});
      run(cag_pkg::OP_DIRECT, 8'h00, 8'h7F, 8'h00, 2'h2, 1'b0, 0);
      chk(ea, 16'h007F);
    end
    for (int b = 0; b < 8; b++) begin
      run(cag_pkg::OP_BITDIR, 8'hA0 + 8'(b), 8'h81, 8'h00, 2'h3, 1'b0, 0);
      chk(ea, 16'h0401);
      chk({13'h0000, bit_sel}, 16'(b));
    end
    note("direct");
    ld(3'h5, 16'h1000);
    run(cag_pkg::OP_EXT, 8'h60, 8'h12, 8'hEF, 2'h3, 1'b0, 3);
    chk(ea, 16'h12EF);
    chk(pc, 16'h1003);
    ld(3'h2, 16'h1000);
    chk(index_reg, 16'h1000);
    run(cag_pkg::OP_INDEX, 8'h06, 8'h80, 8'h00, 2'h2, 1'b0, 0);
    chk(ea, 16'h0F80);
    run(cag_pkg::OP_INDEX, 8'h06, 8'h7F, 8'h00, 2'h2, 1'b0, 0);
    chk(ea, 16'h107F);
    ld(3'h2, 16'hFFF0);
    run(cag_pkg::OP_INDEX, 8'h06, 8'h20, 8'h00, 2'h2, 1'b0, 0);
    chk(ea, 16'h0010);
    ld(3'h3, 16'hBEEF);
    chk(extra_pointer, 16'hBEEF);
    run(cag_pkg::OP_POINTER, 8'h07, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(ea, 16'hBEEF);
    ld(3'h7, 16'h00FF);
    chk({11'h000, bank_select_pointer}, 16'h001F);
    run(cag_pkg::OP_BANKREG, 8'h0E, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(ea, 16'h01FE);
    ld(3'h7, 16'h0005);
    run(cag_pkg::OP_BANKREG, 8'h09, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(ea, 16'h0129);
    run(cag_pkg::OP_IMM, 8'hE4, 8'hA5, 8'h5A, 2'h3, 1'b1, 0);
    chk(imm_data, 16'hA55A);
    chk({15'h0000, imm_word}, 16'h0001);
    run(cag_pkg::OP_IMM, 8'h04, 8'hC3, 8'h00, 2'h2, 1'b0, 0);
    chk(imm_data, 16'h00C3);
    chk({15'h0000, imm_word}, 16'h0000);
    note("modes");
    for (int n = 0; n < 8; n++) begin
      run(cag_pkg::OP_VECTOR, 8'(n), 8'h00, 8'h00, 2'h1, 1'b0, 0);
      chk(pc, {8'h30 + 8'(n), 8'h0B + 8'h11 * 8'(n)});
    end
    note("vector");
    ld(3'h5, 16'h2000);
    run(cag_pkg::OP_REL, 8'hFC, 8'hFE, 8'h00, 2'h2, 1'b0, 0);
    chk(pc, 16'h2000);
    run(cag_pkg::OP_REL, 8'hFC, 8'h7F, 8'h00, 2'h2, 1'b0, 0);
    chk(pc, 16'h2081);
    run(cag_pkg::OP_REL, 8'hFC, 8'h80, 8'h00, 2'h2, 1'b0, 0);
    chk(pc, 16'h2003);
    ld(3'h0, 16'h4321);
    run(cag_pkg::OP_JMPA, 8'hE0, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(pc, 16'h4321);
    ld(3'h5, 16'h1233);
    run(cag_pkg::OP_PCCAP, 8'hF0, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(acc, 16'h1234);
    note("branch");
    ld(3'h0, 16'h0000);
    ld(3'h1, 16'h1234);
    run(cag_pkg::OP_DIVU, 8'h11, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk({15'h0000, zero_flag}, 16'h0001);
    chk(acc, 16'h0000);
    chk(tmp, 16'h1234);
    ld(3'h0, 16'h77FF);
    ld(3'h1, 16'h99FE);
    run(cag_pkg::OP_MULU, 8'h01, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(acc, 16'hFD02);
    chk(tmp, 16'h99FE);
    chk({15'h0000, zero_flag}, 16'h0001);
    ld(3'h0, 16'h0007);
    ld(3'h1, 16'hFFFF);
    run(cag_pkg::OP_DIVU, 8'h11, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(acc, 16'h2492);
    chk(tmp, 16'h0001);
    chk({15'h0000, zero_flag}, 16'h0000);
    ld(3'h0, 16'h0001);
    ld(3'h1, 16'hFFFF);
    run(cag_pkg::OP_DIVU, 8'h11, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(acc, 16'hFFFF);
    chk(tmp, 16'h0000);
    note("arith");
    ld(3'h5, 16'h1234);
    ld(3'h0, 16'h8000);
    run(cag_pkg::OP_PCSWAP, 8'hF4, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(pc, 16'h8000);
    chk(acc, 16'h1235);
    ld(3'h4, 16'h1234);
    ld(3'h5, 16'h5678);
    run(cag_pkg::OP_CALLV, 8'hBB, 8'h00, 8'h00, 2'h1, 1'b0, 0);
    chk(sp, 16'h1232);
    chk({8'h00, u_cag_mem_model.mem[16'h1232]}, 16'h0056);
    chk({8'h00, u_cag_mem_model.mem[16'h1233]}, 16'h0079);
    chk(pc, 16'h333E);
    note("call");
    conclude();
  end
endmodule

// ==== test/cag_mem_model.sv ====
// Program and data memory seen by the address-generation core.
// Assumes one-cycle read latency; vector table preset with known targets.
`timescale 1ns/1ps

module cag_mem_model (
  input wire logic clk_sys,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];

  initial begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    // Target high byte first, low byte at the next address
    for (int n = 0; n < 8; n++) begin
      mem[32'hFFC0 + 2 * n] = 8'h30 + 8'(n);
      mem[32'hFFC1 + 2 * n] = 8'h0B + 8'h11 * 8'(n);
    end
  end

  // Read data only valid one cycle; otherwise it keeps toggling
  always @(posedge clk_sys) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      mem_rdata <= #1 mem[mem_addr];
    end else begin
      mem_rdata <= #1 ~mem_rdata;
    end
  end
endmodule
